// *** logic/prc_pkg.sv ***
// shared constants for the pll runtime reconfiguration link
package prc_pkg;
	localparam int NUM_OUT_DEF = 10;
	localparam int FLD_BITS = 18;
	localparam int CNT_W = 8;
	localparam int LO_POS = 0;
	localparam int HI_POS = 8;
	localparam int BYP_POS = 16;
	localparam int ODD_POS = 17;
	localparam int CP_POS = 7;
	localparam int CP_W = 3;
	localparam int K_POS = 10;
	localparam int LFC_POS = 11;
	localparam int LFC_W = 2;
	localparam int LFR_POS = 13;
	localparam int LFR_W = 5;
	localparam int VCO_TAPS = 8;
	localparam int TAP_W = 3;
	localparam int SEL_W = 4;
	localparam logic [7:0] HI_RST = 8'h01;
	localparam logic [7:0] LO_RST = 8'h01;
	localparam int COARSE_START_DEF = 1;
	localparam int MCLK_HZ = 50_000_000;
	localparam int SCAN_MAX_HZ = 100_000_000;
	localparam int SCAN_HALF_MIN = (MCLK_HZ + 2 * SCAN_MAX_HZ - 1) / (2 * SCAN_MAX_HZ);
	localparam int SCAN_HALF_DEF = 4;
	localparam int AREST_NS = 10;
	localparam int AREST_CYC = (AREST_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;

	function automatic int chain_len(input int n);
		return FLD_BITS * (n + 3);
	endfunction
endpackage

// *** logic/prc_if.sv ***
// interface joining the scan controller and the pll reconfiguration end
`timescale 1ns/1ps
interface prc_if;
	logic scan_clk;
	logic scan_clk_ena;
	logic scan_data;
	logic config_update;
	logic pll_areset;
	logic phase_step;
	logic phase_up;
	logic [prc_pkg::SEL_W-1:0] phase_sel;
	logic scan_done;
	logic scan_data_out;
	logic phase_done;

	modport dev(input scan_clk, input scan_clk_ena, input scan_data, input config_update,
		input pll_areset, input phase_step, input phase_up, input phase_sel,
		output scan_done, output scan_data_out, output phase_done);
	modport ctrl(output scan_clk, output scan_clk_ena, output scan_data, output config_update,
		output pll_areset, output phase_step, output phase_up, output phase_sel,
		input scan_done, input scan_data_out, input phase_done);
endinterface

// *** logic/prc_device.sv ***
// pll end: scan chain, staged divider update, vco phase taps and dividers
// Functional notes
// - any divider may take any of eight taps
// - fine step is one eighth vco period
// - coarse start delays count minus one periods
// - phase step per scan cycle, unlimited, taps only
// - reload pre, feedback, output, post, cp, filter
// - chain shifts scan data while gate high
// - scan clock at most 100 MHz
// - free running scan clock, gate selects cycles
// - gate raised one scan cycle before data
// - first bit captured on second edge
// - shift exactly 234 or 180 bits
// - one scan cycle update strobe applies chain
// - done high while applying, low when loaded
// - each divider loads on its own clock
// - serial output shows chain contents
// - reset pll after feedback, prescale, loop change
// - whole sequence repeatable without limit
// - reapply phase after frequency change
// - first bit is top divider low lsb
// - last bit is loop filter msb
// - divider holds high, low, bypass, odd
// - bypass passes through, else high plus low
`timescale 1ns/1ps
module prc_device #(
	parameter int NUM_OUT = prc_pkg::NUM_OUT_DEF,
	parameter int COARSE_START = prc_pkg::COARSE_START_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	prc_if.dev link,
	output logic [NUM_OUT-1:0] out_clk,
	output logic fb_clk,
	output logic [prc_pkg::FLD_BITS-1:0] pre_div_setting,
	output logic post_vco_div,
	output logic [prc_pkg::CP_W-1:0] cp_current,
	output logic [prc_pkg::LFR_W-1:0] lf_res,
	output logic [prc_pkg::LFC_W-1:0] lf_cap,
	output logic reprog_active
);
	localparam int LEN = prc_pkg::chain_len(NUM_OUT);
	localparam int W = prc_pkg::FLD_BITS;
	localparam int M_BASE = NUM_OUT * W;
	localparam int N_BASE = M_BASE + W;
	localparam int T_BASE = N_BASE + W;
	localparam int IX_CLK = 0;
	localparam int IX_ENA = 1;
	localparam int IX_DAT = 2;
	localparam int IX_UPD = 3;
	localparam int IX_STEP = 4;
	localparam int IX_UP = 5;
	localparam int IX_SEL = 6;
	localparam int SW = IX_SEL + prc_pkg::SEL_W;
	localparam int ND = NUM_OUT + 1;

	typedef enum logic [1:0] {
		PRC_IDLE = 2'b01,
		PRC_APPLY = 2'b10
	} prc_upd_state_type;

	// ************************************
	// input synchronisers
	// ************************************
	logic [SW-1:0] in_w;
	logic [SW-1:0] s1_reg, s2_reg, s3_reg, st_reg, st_next;
	logic sclk_rise;

	assign in_w = {link.phase_sel, link.phase_up, link.phase_step, link.config_update,
		link.scan_data, link.scan_clk_ena, link.scan_clk};

	always_comb begin
		// a bit only moves once the second and third stage agree
		st_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (st_reg & (s2_reg ^ s3_reg));
		sclk_rise = st_next[IX_CLK] & ~st_reg[IX_CLK];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			st_reg <= '0;
		end else begin
			s1_reg <= in_w;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			st_reg <= st_next;
		end
	end

	// ************************************
	// scan chain
	// ************************************
	logic [LEN-1:0] chain_reg, chain_next;
	logic armed_reg, armed_next;

	always_comb begin
		chain_next = chain_reg;
		armed_next = armed_reg;
		if (!st_next[IX_ENA]) begin
			armed_next = 1'b0;
		end else if (sclk_rise) begin
			armed_next = 1'b1;
			if (armed_reg) begin
				// first bit in drifts to index 0, last bit stays at the top
				chain_next = {st_next[IX_DAT], chain_reg[LEN-1:1]};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			chain_reg <= '0;
			armed_reg <= 1'b0;
		end else begin
			chain_reg <= chain_next;
			armed_reg <= armed_next;
		end
	end

	assign link.scan_data_out = chain_reg[0];

	// ************************************
	// update sequencing
	// ************************************
	prc_upd_state_type state_reg, state_next;
	logic [LEN-1:0] shadow_reg, shadow_next;
	logic load_reg, load_next;
	logic done_reg, done_next;
	logic [W-1:0] pre_reg, pre_next;
	logic k_reg, k_next;
	logic [prc_pkg::CP_W-1:0] cp_reg, cp_next;
	logic [prc_pkg::LFR_W-1:0] lfr_reg, lfr_next;
	logic [prc_pkg::LFC_W-1:0] lfc_reg, lfc_next;
	logic [ND-1:0] pend_w;

	always_comb begin
		state_next = state_reg;
		shadow_next = shadow_reg;
		load_next = 1'b0;
		done_next = done_reg;
		pre_next = pre_reg;
		k_next = k_reg;
		cp_next = cp_reg;
		lfr_next = lfr_reg;
		lfc_next = lfc_reg;
		case (state_reg)
			PRC_IDLE: begin
				if (sclk_rise && st_next[IX_UPD]) begin
					shadow_next = chain_reg;
					load_next = 1'b1;
					done_next = 1'b1;
					pre_next = chain_reg[N_BASE +: W];
					k_next = chain_reg[T_BASE + prc_pkg::K_POS];
					cp_next = chain_reg[T_BASE + prc_pkg::CP_POS +: prc_pkg::CP_W];
					lfr_next = chain_reg[T_BASE + prc_pkg::LFR_POS +: prc_pkg::LFR_W];
					lfc_next = chain_reg[T_BASE + prc_pkg::LFC_POS +: prc_pkg::LFC_W];
					state_next = PRC_APPLY;
				end
			end
			PRC_APPLY: begin
				// pend bits rise one cycle after the load pulse
				if (!load_reg && pend_w == '0) begin
					done_next = 1'b0;
					state_next = PRC_IDLE;
				end
			end
			default: begin
				state_next = PRC_IDLE;
				done_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= PRC_IDLE;
			shadow_reg <= '0;
			load_reg <= 1'b0;
			done_reg <= 1'b0;
			pre_reg <= '0;
			k_reg <= 1'b0;
			cp_reg <= '0;
			lfr_reg <= '0;
			lfc_reg <= '0;
		end else begin
			state_reg <= state_next;
			shadow_reg <= shadow_next;
			load_reg <= load_next;
			done_reg <= done_next;
			pre_reg <= pre_next;
			k_reg <= k_next;
			cp_reg <= cp_next;
			lfr_reg <= lfr_next;
			lfc_reg <= lfc_next;
		end
	end

	assign link.scan_done = done_reg;
	assign reprog_active = done_reg;
	assign pre_div_setting = pre_reg;
	assign post_vco_div = k_reg;
	assign cp_current = cp_reg;
	assign lf_res = lfr_reg;
	assign lf_cap = lfc_reg;

	// ************************************
	// vco phases and phase stepping
	// ************************************
	// one mclk stands for one eighth of a vco period
	logic [prc_pkg::TAP_W-1:0] vco_reg, vco_next;
	logic pstep;
	logic pdone_reg;

	always_comb begin
		vco_next = vco_reg + 3'h1;
		pstep = sclk_rise & st_next[IX_STEP];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			vco_reg <= '0;
			pdone_reg <= 1'b0;
		end else begin
			vco_reg <= vco_next;
			pdone_reg <= pstep;
		end
	end

	assign link.phase_done = pdone_reg;

	// ************************************
	// dividers, last one is the feedback
	// ************************************
	logic [ND-1:0] dout_w;

	for (genvar g = 0; g < ND; g++) begin : g_div
		localparam int BASE = (g == NUM_OUT) ? M_BASE : (NUM_OUT - 1 - g) * W;
		logic [prc_pkg::TAP_W-1:0] tap_reg, tap_next, diff;
		logic [prc_pkg::CNT_W-1:0] hi_reg, hi_next, lo_reg, lo_next;
		logic [prc_pkg::CNT_W-1:0] cnt_reg, cnt_next, crs_reg, crs_next;
		logic byp_reg, byp_next, odd_reg, odd_next, half_reg, half_next;
		logic out_reg, out_next, pend_reg, pend_next, tick;

		always_comb begin
			tap_next = tap_reg;
			hi_next = hi_reg;
			lo_next = lo_reg;
			byp_next = byp_reg;
			odd_next = odd_reg;
			cnt_next = cnt_reg;
			crs_next = crs_reg;
			half_next = half_reg;
			out_next = out_reg;
			pend_next = pend_reg | load_reg;
			tick = (vco_reg == tap_reg);
			diff = vco_reg - tap_reg;
			if (pstep && st_next[IX_SEL +: prc_pkg::SEL_W] == prc_pkg::SEL_W'(g)) begin
				tap_next = st_next[IX_UP] ? tap_reg + 3'h1 : tap_reg - 3'h1;
			end
			if (link.pll_areset) begin
				crs_next = prc_pkg::CNT_W'(COARSE_START - 1);
				cnt_next = '0;
				half_next = 1'b0;
				out_next = 1'b0;
			end else if (half_reg && diff == 3'h4) begin
				// odd divide drops half a vco period late
				half_next = 1'b0;
				out_next = 1'b0;
			end else if (tick && pend_reg && !load_reg) begin
				hi_next = shadow_reg[BASE + prc_pkg::HI_POS +: prc_pkg::CNT_W];
				lo_next = shadow_reg[BASE + prc_pkg::LO_POS +: prc_pkg::CNT_W];
				byp_next = shadow_reg[BASE + prc_pkg::BYP_POS];
				odd_next = shadow_reg[BASE + prc_pkg::ODD_POS];
				pend_next = 1'b0;
				cnt_next = '0;
				out_next = 1'b1;
			end else if (crs_reg != '0) begin
				if (tick) begin
					crs_next = crs_reg - 8'h01;
				end
				out_next = 1'b0;
			end else if (byp_reg) begin
				out_next = ~diff[prc_pkg::TAP_W-1];
			end else if (tick) begin
				cnt_next = cnt_reg + 8'h01;
				if (out_reg && cnt_reg + 8'h01 >= hi_reg) begin
					cnt_next = '0;
					half_next = odd_reg;
					out_next = odd_reg;
				end else if (!out_reg && cnt_reg + 8'h01 >= lo_reg) begin
					cnt_next = '0;
					out_next = 1'b1;
				end
			end
		end

		always_ff @(posedge mclk) begin
			if (rst) begin
				tap_reg <= '0;
				hi_reg <= prc_pkg::HI_RST;
				lo_reg <= prc_pkg::LO_RST;
				byp_reg <= 1'b0;
				odd_reg <= 1'b0;
				cnt_reg <= '0;
				crs_reg <= prc_pkg::CNT_W'(COARSE_START - 1);
				half_reg <= 1'b0;
				out_reg <= 1'b0;
				pend_reg <= 1'b0;
			end else begin
				tap_reg <= tap_next;
				hi_reg <= hi_next;
				lo_reg <= lo_next;
				byp_reg <= byp_next;
				odd_reg <= odd_next;
				cnt_reg <= cnt_next;
				crs_reg <= crs_next;
				half_reg <= half_next;
				out_reg <= out_next;
				pend_reg <= pend_next;
			end
		end

		assign pend_w[g] = pend_reg;
		assign dout_w[g] = out_reg;
	end

	assign out_clk = dout_w[NUM_OUT-1:0];
	assign fb_clk = dout_w[NUM_OUT];
endmodule

// *** logic/prc_ctrl.sv ***
// controller end: makes the scan clock and drives shift, update and phase steps
`timescale 1ns/1ps
module prc_ctrl #(
	parameter int NUM_OUT = prc_pkg::NUM_OUT_DEF,
	parameter int SCAN_HALF = prc_pkg::SCAN_HALF_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	prc_if.ctrl link,
	input wire logic [prc_pkg::chain_len(NUM_OUT)-1:0] cfg_data,
	input wire logic cfg_start,
	input wire logic phase_req,
	input wire logic phase_up_in,
	input wire logic [prc_pkg::SEL_W-1:0] phase_sel_in,
	output logic busy,
	output logic cfg_done
);
	localparam int LEN = prc_pkg::chain_len(NUM_OUT);
	localparam int KEEP = 3 * prc_pkg::FLD_BITS;
	localparam int HW = $clog2(SCAN_HALF + 1);
	localparam logic [HW-1:0] HALF_LAST = HW'(SCAN_HALF - 1);

	typedef enum logic [6:0] {
		PRC_C_IDLE = 7'b0000001,
		PRC_C_ARM = 7'b0000010,
		PRC_C_SHIFT = 7'b0000100,
		PRC_C_UPD = 7'b0001000,
		PRC_C_WAIT = 7'b0010000,
		PRC_C_RST = 7'b0100000,
		PRC_C_PHASE = 7'b1000000
	} prc_ctrl_state_type;

	// ************************************
	// free running scan clock divider
	// ************************************
	logic [HW-1:0] hc_reg, hc_next;
	logic sclk_reg, sclk_next, sfall;

	always_comb begin
		hc_next = (hc_reg == HALF_LAST) ? '0 : hc_reg + HW'(1);
		sclk_next = (hc_reg == HALF_LAST) ? ~sclk_reg : sclk_reg;
		sfall = (hc_reg == HALF_LAST) & sclk_reg;
	end

	// ************************************
	// sequencer
	// ************************************
	prc_ctrl_state_type state_reg, state_next;
	logic [LEN-1:0] sh_reg, sh_next;
	logic [KEEP-1:0] prev_reg, prev_next;
	logic [$clog2(LEN+1)-1:0] bit_reg, bit_next;
	logic ena_reg, ena_next, dat_reg, dat_next, upd_reg, upd_next;
	logic step_reg, step_next, up_reg, up_next, seen_reg, seen_next;
	logic areset_reg, areset_next, cpend_reg, cpend_next, ppend_reg, ppend_next;
	logic done_reg, done_next, busy_reg, busy_next;
	logic [prc_pkg::SEL_W-1:0] sel_reg, sel_next;
	logic [3:0] rc_reg, rc_next;

	always_comb begin
		state_next = state_reg;
		sh_next = sh_reg;
		prev_next = prev_reg;
		bit_next = bit_reg;
		ena_next = ena_reg;
		dat_next = dat_reg;
		upd_next = upd_reg;
		step_next = step_reg;
		up_next = up_reg;
		sel_next = sel_reg;
		seen_next = seen_reg;
		areset_next = 1'b0;
		rc_next = rc_reg;
		done_next = 1'b0;
		// requests are remembered so a short pulse is never lost
		cpend_next = cpend_reg | cfg_start;
		ppend_next = ppend_reg | phase_req;
		case (state_reg)
			PRC_C_IDLE: begin
				if (sfall && cpend_reg) begin
					cpend_next = cfg_start;
					sh_next = cfg_data;
					ena_next = 1'b1;
					bit_next = '0;
					state_next = PRC_C_ARM;
				end else if (sfall && ppend_reg) begin
					ppend_next = phase_req;
					step_next = 1'b1;
					up_next = phase_up_in;
					sel_next = phase_sel_in;
					state_next = PRC_C_PHASE;
				end
			end
			PRC_C_ARM: begin
				if (sfall) begin
					dat_next = sh_reg[0];
					state_next = PRC_C_SHIFT;
				end
			end
			PRC_C_SHIFT: begin
				if (sfall) begin
					if (bit_reg == ($clog2(LEN+1))'(LEN - 1)) begin
						ena_next = 1'b0;
						dat_next = 1'b0;
						upd_next = 1'b1;
						seen_next = 1'b0;
						// last turn brings the image back whole for the change test
						sh_next = {sh_reg[0], sh_reg[LEN-1:1]};
						state_next = PRC_C_UPD;
					end else begin
						bit_next = bit_reg + 1'b1;
						// rotate rather than drain, the top fields are compared later
						sh_next = {sh_reg[0], sh_reg[LEN-1:1]};
						dat_next = sh_reg[1];
					end
				end
			end
			PRC_C_UPD: begin
				seen_next = seen_reg | link.scan_done;
				if (sfall) begin
					upd_next = 1'b0;
					state_next = PRC_C_WAIT;
				end
			end
			PRC_C_WAIT: begin
				seen_next = seen_reg | link.scan_done;
				if (seen_reg && !link.scan_done) begin
					prev_next = sh_reg[LEN-1 -: KEEP];
					if (sh_reg[LEN-1 -: KEEP] != prev_reg) begin
						areset_next = 1'b1;
						rc_next = 4'(prc_pkg::AREST_CYC);
						state_next = PRC_C_RST;
					end else begin
						done_next = 1'b1;
						state_next = PRC_C_IDLE;
					end
				end
			end
			PRC_C_RST: begin
				if (rc_reg > 4'h1) begin
					areset_next = 1'b1;
					rc_next = rc_reg - 4'h1;
				end else begin
					done_next = 1'b1;
					state_next = PRC_C_IDLE;
				end
			end
			PRC_C_PHASE: begin
				if (sfall) begin
					step_next = 1'b0;
					state_next = PRC_C_IDLE;
				end
			end
			default: begin
				state_next = PRC_C_IDLE;
			end
		endcase
		busy_next = (state_next != PRC_C_IDLE);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hc_reg <= '0;
			sclk_reg <= 1'b0;
			state_reg <= PRC_C_IDLE;
			sh_reg <= '0;
			prev_reg <= '0;
			bit_reg <= '0;
			ena_reg <= 1'b0;
			dat_reg <= 1'b0;
			upd_reg <= 1'b0;
			step_reg <= 1'b0;
			up_reg <= 1'b0;
			sel_reg <= '0;
			seen_reg <= 1'b0;
			areset_reg <= 1'b0;
			rc_reg <= '0;
			cpend_reg <= 1'b0;
			ppend_reg <= 1'b0;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			hc_reg <= hc_next;
			sclk_reg <= sclk_next;
			state_reg <= state_next;
			sh_reg <= sh_next;
			prev_reg <= prev_next;
			bit_reg <= bit_next;
			ena_reg <= ena_next;
			dat_reg <= dat_next;
			upd_reg <= upd_next;
			step_reg <= step_next;
			up_reg <= up_next;
			sel_reg <= sel_next;
			seen_reg <= seen_next;
			areset_reg <= areset_next;
			rc_reg <= rc_next;
			cpend_reg <= cpend_next;
			ppend_reg <= ppend_next;
			done_reg <= done_next;
			busy_reg <= busy_next;
		end
	end

	assign link.scan_clk = sclk_reg;
	assign link.scan_clk_ena = ena_reg;
	assign link.scan_data = dat_reg;
	assign link.config_update = upd_reg;
	assign link.pll_areset = areset_reg;
	assign link.phase_step = step_reg;
	assign link.phase_up = up_reg;
	assign link.phase_sel = sel_reg;
	assign busy = busy_reg;
	assign cfg_done = done_reg;
endmodule

// *** verification/prc_props.sv ***
// checker for the scan link between the controller and the pll end
`timescale 1ns/1ps
module prc_props #(
	parameter int SCAN_HALF = prc_pkg::SCAN_HALF_DEF
) (
	input logic mclk,
	input logic rst,
	input logic scan_clk,
	input logic scan_clk_ena,
	input logic scan_data,
	input logic config_update,
	input logic pll_areset,
	input logic phase_step,
	input logic scan_done,
	input logic phase_done
);
	// *****
	// helpers
	// *****
	int hi_cnt;

	always_ff @(posedge mclk) begin
		if (rst || !scan_clk) begin
			hi_cnt <= 0;
		end else begin
			hi_cnt <= hi_cnt + 1;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// *****
	// properties
	// *****
	sequence s_update_hold;
		config_update [*8] ##1 !config_update;
	endsequence
	sequence s_apply;
		##[2:16] $rose(scan_done) ##[1:40] $fell(scan_done);
	endsequence
	property p_scan_high;
		$fell(scan_clk) |-> hi_cnt == SCAN_HALF;
	endproperty
	property p_data_on_fall;
		$changed(scan_data) |-> $fell(scan_clk);
	endproperty
	property p_gate_on_fall;
		$changed(scan_clk_ena) |-> $fell(scan_clk);
	endproperty
	property p_gate_lead;
		$rose(scan_clk_ena) |-> $stable(scan_data) [*8];
	endproperty
	property p_update_len;
		$rose(config_update) |-> s_update_hold;
	endproperty
	property p_update_gate;
		config_update |-> !scan_clk_ena;
	endproperty
	property p_apply;
		$rose(config_update) |-> s_apply;
	endproperty
	property p_step_done;
		$rose(phase_step) |-> ##[2:16] phase_done ##1 !phase_done;
	endproperty
	property p_areset;
		pll_areset |-> !scan_done ##1 !pll_areset;
	endproperty

	a_scan_high: assert property (p_scan_high)
		else $error("scan clock high phase has the wrong length");
	a_data_on_fall: assert property (p_data_on_fall)
		else $error("serial data moved away from a falling scan edge");
	a_gate_on_fall: assert property (p_gate_on_fall)
		else $error("gate moved away from a falling scan edge");
	a_gate_lead: assert property (p_gate_lead)
		else $error("data moved within one scan cycle of the gate");
	a_update_len: assert property (p_update_len)
		else $error("update strobe not one scan cycle long");
	a_update_gate: assert property (p_update_gate)
		else $error("update strobe while the gate is high");
	a_apply: assert property (p_apply)
		else $error("apply window missing or too long");
	a_step_done: assert property (p_step_done)
		else $error("phase step not answered by one pulse");
	a_areset: assert property (p_areset)
		else $error("pll reset during apply or too long");
endmodule

// *** verification/pll_runtime_reconfig_and_phase_shift_bench.sv ***
// self-checking bench joining the scan controller and the pll end
`timescale 1ns/1ps
module pll_runtime_reconfig_and_phase_shift_bench;
	localparam int NO = 7;
	localparam int SH = prc_pkg::SCAN_HALF_DEF;
	localparam int FB = prc_pkg::FLD_BITS;
	localparam int LEN = prc_pkg::chain_len(NO);
	localparam int TL = (NO + 2) * FB;
	localparam int VCO = prc_pkg::VCO_TAPS;
	logic mclk, rst, cfg_start, phase_req, phase_up_in, busy, cfg_done;
	logic fb_clk, post_vco_div, reprog_active, done_prev;
	logic [LEN-1:0] cfg_data, img;
	logic [prc_pkg::SEL_W-1:0] phase_sel_in;
	logic [NO-1:0] out_clk;
	logic [NO:0] clks;
	logic [FB-1:0] pre_div_setting;
	logic [prc_pkg::CP_W-1:0] cp_current;
	logic [prc_pkg::LFR_W-1:0] lf_res;
	logic [prc_pkg::LFC_W-1:0] lf_cap;
	int num_errors, checked, arst_cnt, done_cnt, step_cnt, fin_cnt, ph_gap;

	prc_if link();
	prc_device #(.NUM_OUT(NO)) i_prc_device (.mclk(mclk), .rst(rst), .link(link),
		.out_clk(out_clk), .fb_clk(fb_clk), .pre_div_setting(pre_div_setting),
		.post_vco_div(post_vco_div), .cp_current(cp_current), .lf_res(lf_res),
		.lf_cap(lf_cap), .reprog_active(reprog_active));
	prc_ctrl #(.NUM_OUT(NO), .SCAN_HALF(SH)) i_prc_ctrl (.mclk(mclk), .rst(rst), .link(link),
		.cfg_data(cfg_data), .cfg_start(cfg_start), .phase_req(phase_req),
		.phase_up_in(phase_up_in), .phase_sel_in(phase_sel_in), .busy(busy),
		.cfg_done(cfg_done));
	prc_props #(.SCAN_HALF(SH)) i_prc_props (.mclk(mclk), .rst(rst),
		.scan_clk(link.scan_clk), .scan_clk_ena(link.scan_clk_ena),
		.scan_data(link.scan_data), .config_update(link.config_update),
		.pll_areset(link.pll_areset), .phase_step(link.phase_step),
		.scan_done(link.scan_done), .phase_done(link.phase_done));

	assign clks = {fb_clk, out_clk};

	always @(posedge mclk) begin
		if (link.pll_areset === 1'b1) begin
			arst_cnt <= arst_cnt + 1;
		end
		if (link.phase_done === 1'b1) begin
			step_cnt <= step_cnt + 1;
		end
		if (cfg_done === 1'b1) begin
			fin_cnt <= fin_cnt + 1;
		end
		if (reprog_active === 1'b1 && done_prev === 1'b0) begin
			done_cnt <= done_cnt + 1;
		end
		done_prev <= reprog_active;
	end

	// *****
	// shared tasks
	// *****
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_idle(input int lim);
		int n;
		n = 0;
		// a request is only taken at the next falling scan edge
		while (busy !== 1'b1 && n < lim) begin
			@(negedge mclk);
			n++;
		end
		chk("busy taken", 1, busy);
		while (busy !== 1'b0 && n < lim) begin
			@(negedge mclk);
			n++;
		end
		// done pulses land with busy falling, let the counters catch them
		repeat (2) @(negedge mclk);
		chk("busy after wait", 0, busy);
	endtask

	// counts falling edges up to the next rise of one divider output
	task automatic wait_rise(input int i, inout int n);
		logic p;
		p = clks[i];
		forever begin
			@(negedge mclk);
			n++;
			if ((clks[i] === 1'b1 && p === 1'b0) || n > 400) break;
			p = clks[i];
		end
	endtask

	task automatic gap(input int a, input int b, output int n);
		int d;
		d = 0;
		wait_rise(a, d);
		n = 0;
		wait_rise(b, n);
	endtask

	task automatic chk_period(input int i, input int exp);
		int n;
		gap(i, i, n);
		chk("divider period", exp, n);
	endtask

	// g of -1 is the feedback field, -2 the prescale field
	function automatic logic [LEN-1:0] set_div(input logic [LEN-1:0] v, input int g,
		input logic [7:0] hi, input logic [7:0] lo, input logic byp);
		int b;
		b = (NO - 1 - g) * FB;
		v[b + prc_pkg::LO_POS +: 8] = lo;
		v[b + prc_pkg::HI_POS +: 8] = hi;
		v[b + prc_pkg::BYP_POS] = byp;
		return v;
	endfunction

	task automatic do_cfg(input int exp_rst);
		int a0, d0, f0;
		a0 = arst_cnt;
		d0 = done_cnt;
		f0 = fin_cnt;
		cfg_data = img;
		cfg_start = 1'b1;
		@(negedge mclk);
		cfg_start = 1'b0;
		wait_idle(4000);
		chk("pll reset pulses", exp_rst, arst_cnt - a0);
		chk("apply windows", 1, done_cnt - d0);
		chk("done pulses", 1, fin_cnt - f0);
		chk("chain end bit", img[0], link.scan_data_out);
		chk("filter resistor", img[TL + prc_pkg::LFR_POS +: prc_pkg::LFR_W], lf_res);
	endtask

	task automatic step(input logic [prc_pkg::SEL_W-1:0] sel, input logic up);
		phase_sel_in = sel;
		phase_up_in = up;
		phase_req = 1'b1;
		@(negedge mclk);
		phase_req = 1'b0;
		wait_idle(200);
	endtask

	// *****
	// scenarios
	// *****
	task automatic t_reset;
		chk("apply flag", 0, link.scan_done);
		chk("chain output", 0, link.scan_data_out);
		chk("cp current", 0, cp_current);
		chk_period(0, 2 * VCO);
		$display("test reset values done");
	endtask

	task automatic t_cfg_first;
		img = '0;
		img = set_div(img, 0, 8'h02, 8'h03, 1'b0);
		img = set_div(img, 1, 8'h00, 8'h00, 1'b1);
		img = set_div(img, NO - 1, 8'h01, 8'h01, 1'b0);
		img = set_div(img, -1, 8'h02, 8'h02, 1'b0);
		img = set_div(img, -2, 8'h01, 8'h03, 1'b0);
		img[TL + prc_pkg::CP_POS +: prc_pkg::CP_W] = 3'h3;
		img[TL + prc_pkg::K_POS] = 1'b1;
		img[TL + prc_pkg::LFC_POS +: prc_pkg::LFC_W] = 2'h2;
		img[TL + prc_pkg::LFR_POS +: prc_pkg::LFR_W] = 5'h11;
		do_cfg(1);
		chk("cp current", 3'h3, cp_current);
		chk("post vco divider", 1, post_vco_div);
		chk("filter cap", 2'h2, lf_cap);
		chk("prescale field", img[(NO + 1) * FB +: FB], pre_div_setting);
		chk_period(0, 5 * VCO);
		chk_period(1, VCO);
		chk_period(NO, 4 * VCO);
		$display("test first config done");
	endtask

	task automatic t_phase;
		int d0, d1, s0;
		s0 = step_cnt;
		gap(2, 3, d0);
		repeat (3) step(4'h3, 1'b1);
		chk("phase steps", 3, step_cnt - s0);
		gap(2, 3, d1);
		chk("fine shift", (d0 + 3) % (2 * VCO), d1 % (2 * VCO));
		step(4'h3, 1'b0);
		gap(2, 3, d1);
		ph_gap = d1 % (2 * VCO);
		chk("fine shift back", (d0 + 2) % (2 * VCO), ph_gap);
		step(4'h7, 1'b1);
		chk("feedback step", 5, step_cnt - s0);
		$display("test phase steps done");
	endtask

	task automatic t_cfg_repeat;
		int d;
		img = set_div(img, 0, 8'h01, 8'h01, 1'b0);
		do_cfg(0);
		chk_period(0, 2 * VCO);
		gap(2, 3, d);
		// dividers restart in their own order, only the tap offset survives
		chk("phase kept", ph_gap % VCO, d % VCO);
		img[TL + prc_pkg::CP_POS +: prc_pkg::CP_W] = 3'h7;
		do_cfg(1);
		chk("cp current", 3'h7, cp_current);
		$display("test repeat config done");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// about twelve times the expected run
	initial begin
		#1200000;
		num_errors++;
		$display("MISMATCH watchdog expected finish seen hang");
		stop_test;
	end

	initial begin
		rst = 1'b1;
		cfg_start = 1'b0;
		phase_req = 1'b0;
		phase_up_in = 1'b0;
		phase_sel_in = '0;
		cfg_data = '0;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		t_reset;
		t_cfg_first;
		t_phase;
		t_cfg_repeat;
		stop_test;
	end
endmodule
